// >>> hdl/lsp_pkg.sv
// Purpose: shared constants and types of the led string select pwm controller
// Assumes: 125 MHz system clock
// Notes: all timing counts are derived from the times below
package lsp_pkg;

    // clock
    localparam int CLOCK_HZ = 125_000_000;
    localparam int CLOCK_PERIOD_NS = 8;

    // switching cycle
    localparam int FOSC_HZ = 66_000;
    localparam int PERIOD_CYC = CLOCK_HZ / FOSC_HZ;
    localparam int MAX_DUTY_PCT = 79;
    localparam int MAX_ON_CYC = (PERIOD_CYC * MAX_DUTY_PCT) / 100;
    localparam int MIN_ON_TIME_NS = 250;
    localparam int MIN_ON_CYC = (MIN_ON_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int BLANK_TIME_NS = 750;
    localparam int BLANK_CYC = (BLANK_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int FOLDBACK_PERIODS = 3;

    // line-off debounce
    localparam int LINE_OFF_DEBOUNCE_MS = 19;
    localparam int LINE_OFF_DEBOUNCE_CYC = LINE_OFF_DEBOUNCE_MS * (CLOCK_HZ / 1000);

    // state widths
    localparam int CYC_W = 11;
    localparam int DEB_W = 22;
    localparam int SKIP_W = 2;

    localparam logic [CYC_W-1:0] PERIOD_LAST = CYC_W'(PERIOD_CYC - 1);
    localparam logic [CYC_W-1:0] MAX_ON_LAST = CYC_W'(MAX_ON_CYC - 1);
    localparam logic [CYC_W-1:0] MIN_ON_LAST = CYC_W'(MIN_ON_CYC - 1);
    localparam logic [CYC_W-1:0] BLANK_END = CYC_W'(BLANK_CYC);
    localparam logic [SKIP_W-1:0] FOLD_SKIP = SKIP_W'(FOLDBACK_PERIODS);

    // string select codes, bit 0 drives string one
    localparam logic [1:0] SEL_STRING_ONE = 2'h1;

    typedef enum logic [1:0] {
        PWR_OFF,
        PWR_RUN,
        PWR_HALT
    } lsp_pwr_t;

    // comparator flags as seen by the control logic
    typedef struct packed {
        logic vdd_above_on;
        logic vdd_above_off;
        logic vdd_below_reset;
        logic line_above_on;
        logic line_below_off;
        logic ramp_at_error;
        logic cs_above_limit;
        logic cs_above_short;
    } lsp_cmp_t;

    typedef struct packed {
        lsp_cmp_t s1;
        lsp_cmp_t s2;
        lsp_cmp_t s3;
        lsp_cmp_t filt;
    } lsp_sync_t;

    typedef struct packed {
        lsp_pwr_t pwr;
        logic [1:0] sel;
        logic swap_pending;
        logic line_present;
        logic [DEB_W-1:0] deb;
        logic [CYC_W-1:0] cyc;
        logic [SKIP_W-1:0] skip;
        logic gate;
    } lsp_state_t;

    localparam lsp_state_t STATE_RESET = '{
        pwr: PWR_OFF,
        sel: SEL_STRING_ONE,
        swap_pending: 1'b0,
        line_present: 1'b0,
        deb: '0,
        cyc: '0,
        skip: '0,
        gate: 1'b0
    };

endpackage

// >>> hdl/lsp_sync.sv
// Purpose: three-stage synchroniser and agreement filter for comparator flags
// Assumes: flags are asynchronous to the clock
// Notes: a flag changes once the second and third stages agree
`timescale 1ns/1ps
module lsp_sync
    import lsp_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clk_en,
    // flags
    input wire lsp_cmp_t raw,
    output lsp_cmp_t filt
);

    lsp_sync_t st_q;
    lsp_sync_t st_d;

    // the first stage feeds only the second
    always_comb begin
        st_d = st_q;
        st_d.s1 = raw;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        st_d.filt = (st_q.s2 & st_q.s3) | (st_q.filt & (st_q.s2 | st_q.s3));
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= '0;
        end else if (clk_en) begin
            st_q <= st_d;
        end
    end

    assign filt = st_q.filt;

endmodule

// >>> hdl/lsp_ctrl.sv
// Purpose: gate-drive pwm, supply sequencing and led string select state machine
// Assumes: comparator flags arrive asynchronously; one 125 MHz clock
// Notes: assertions expect CLK_EN held high while they run
// Functional notes
// - no switching until supply rises above turn-on level.
// - below turn-off level gate stops, string select logic keeps state.
// - below reset level all logic resets, string one selected next.
// - fixed 66 kHz cycle, each cycle outside foldback skips starts a new gate pulse.
// - pulse ends when ramp reaches error level.
// - pulse ends by 79 percent of the period.
// - each pulse lasts at least 250 ns.
// - line present above on threshold, absent below off threshold.
// - after first power-up string one selected, string two off.
// - line absent starts a 19 ms timer.
// - timer expiry before supply drop swaps selection at next power-up.
// - gate drive stops as soon as the timer expires.
// - each qualifying off-on cycle toggles selection, exactly one active.
// - current sense ignored for first 750 ns of each cycle.
// - current limit ends the pulse, next cycle pulses again.
// - short level ends pulse and skips three cycles.
`timescale 1ns/1ps
module lsp_ctrl
    import lsp_pkg::*;
#(
    parameter int unsigned DEBOUNCE_CYCLES = LINE_OFF_DEBOUNCE_CYC
)
(
    // clock and reset
    input wire logic CLOCK,
    input wire logic RST_B,
    input wire logic CLK_EN,
    // supply comparators
    input wire logic VDD_ABOVE_ON,
    input wire logic VDD_ABOVE_OFF,
    input wire logic VDD_BELOW_RESET,
    // line detect comparators
    input wire logic LINE_ABOVE_ON,
    input wire logic LINE_BELOW_OFF,
    // pwm and current sense comparators
    input wire logic RAMP_AT_ERROR,
    input wire logic CS_ABOVE_LIMIT,
    input wire logic CS_ABOVE_SHORT,
    // outputs
    output logic GATE_DRIVE_OUT,
    output logic STRING_ONE_SELECT,
    output logic STRING_TWO_SELECT
);

    localparam logic [DEB_W-1:0] DEB_LAST = DEB_W'(DEBOUNCE_CYCLES - 1);

    lsp_cmp_t raw;
    lsp_cmp_t cmp;
    lsp_state_t st_q;
    lsp_state_t st_d;
    logic sense_open;

    assign raw = '{
        vdd_above_on: VDD_ABOVE_ON,
        vdd_above_off: VDD_ABOVE_OFF,
        vdd_below_reset: VDD_BELOW_RESET,
        line_above_on: LINE_ABOVE_ON,
        line_below_off: LINE_BELOW_OFF,
        ramp_at_error: RAMP_AT_ERROR,
        cs_above_limit: CS_ABOVE_LIMIT,
        cs_above_short: CS_ABOVE_SHORT
    };

    lsp_sync u_sync (
        .clk(CLOCK),
        .rst_b(RST_B),
        .clk_en(CLK_EN),
        .raw(raw),
        .filt(cmp)
    );

    // current sense looked at only after the blanking window
    assign sense_open = (st_q.cyc >= BLANK_END);

    always_comb begin
        st_d = st_q;
        if (cmp.line_above_on) begin
            st_d.line_present = 1'b1;
        end else if (cmp.line_below_off) begin
            st_d.line_present = 1'b0;
        end
        case (st_q.pwr)
            PWR_OFF: begin
                st_d.gate = 1'b0;
                st_d.cyc = '0;
                st_d.skip = '0;
                st_d.deb = '0;
                if (cmp.vdd_above_on && cmp.vdd_above_off) begin
                    st_d.pwr = PWR_RUN;
                    st_d.gate = 1'b1;
                    if (st_q.swap_pending) begin
                        st_d.sel = {st_q.sel[0], st_q.sel[1]};
                    end
                    st_d.swap_pending = 1'b0;
                end
            end
            PWR_RUN: begin
                if (!cmp.vdd_above_off) begin
                    // supply lost first: no swap, selection held
                    st_d.pwr = PWR_OFF;
                    st_d.gate = 1'b0;
                    st_d.deb = '0;
                end else if (!st_q.line_present && st_q.deb == DEB_LAST) begin
                    st_d.pwr = PWR_HALT;
                    st_d.gate = 1'b0;
                    st_d.swap_pending = 1'b1;
                    st_d.deb = '0;
                end else begin
                    if (st_q.line_present) begin
                        st_d.deb = '0;
                    end else begin
                        st_d.deb = st_q.deb + 1'b1;
                    end
                    if (st_q.cyc == PERIOD_LAST) begin
                        st_d.cyc = '0;
                        if (st_q.skip != '0) begin
                            st_d.skip = st_q.skip - 1'b1;
                            st_d.gate = 1'b0;
                        end else begin
                            st_d.gate = 1'b1;
                        end
                    end else begin
                        st_d.cyc = st_q.cyc + 1'b1;
                        if (st_q.gate) begin
                            if (sense_open && cmp.cs_above_short) begin
                                st_d.gate = 1'b0;
                                st_d.skip = FOLD_SKIP;
                            end else if (sense_open && cmp.cs_above_limit) begin
                                st_d.gate = 1'b0;
                            end else if (st_q.cyc >= MIN_ON_LAST && cmp.ramp_at_error) begin
                                st_d.gate = 1'b0;
                            end else if (st_q.cyc >= MAX_ON_LAST) begin
                                st_d.gate = 1'b0;
                            end
                        end
                    end
                end
            end
            PWR_HALT: begin
                // wait for the supply to fall before a new power-up
                st_d.gate = 1'b0;
                st_d.cyc = '0;
                st_d.skip = '0;
                st_d.deb = '0;
                if (!cmp.vdd_above_off) begin
                    st_d.pwr = PWR_OFF;
                end
            end
            default: begin
                st_d = STATE_RESET;
            end
        endcase
        if (cmp.vdd_below_reset) begin
            st_d = STATE_RESET;
        end
    end

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            st_q <= STATE_RESET;
        end else if (CLK_EN) begin
            st_q <= st_d;
        end
    end

    assign GATE_DRIVE_OUT = st_q.gate;
    assign STRING_ONE_SELECT = st_q.sel[0];
    assign STRING_TWO_SELECT = st_q.sel[1];

    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RST_B || !CLK_EN);

    one_hot_select_a: assert property (
        STRING_ONE_SELECT != STRING_TWO_SELECT
    ) else $error("string selects not exactly one active");

    off_no_gate_a: assert property (
        st_q.pwr != PWR_RUN |-> !GATE_DRIVE_OUT
    ) else $error("gate drive active outside run state");

    supply_drop_a: assert property (
        (st_q.pwr == PWR_RUN && !cmp.vdd_above_off && !cmp.vdd_below_reset)
            |=> (!GATE_DRIVE_OUT && $stable(st_q.sel))
    ) else $error("supply drop did not stop gate or changed selection");

    low_reset_a: assert property (
        cmp.vdd_below_reset |=> (st_q.pwr == PWR_OFF && STRING_ONE_SELECT && !st_q.swap_pending)
    ) else $error("reset level did not clear control logic");

    period_wrap_a: assert property (
        (st_q.pwr == PWR_RUN && st_q.cyc == PERIOD_LAST && cmp.vdd_above_off && st_q.line_present
            && !cmp.vdd_below_reset && st_q.skip == '0) |=> (st_q.cyc == '0 && GATE_DRIVE_OUT)
    ) else $error("switching cycle did not restart with a pulse");

    pulse_start_a: assert property (
        $rose(GATE_DRIVE_OUT) |-> st_q.cyc == '0
    ) else $error("gate pulse started mid cycle");

    ramp_end_a: assert property (
        (st_q.pwr == PWR_RUN && GATE_DRIVE_OUT && cmp.ramp_at_error && st_q.cyc >= MIN_ON_LAST
            && st_q.cyc != PERIOD_LAST) |=> !GATE_DRIVE_OUT
    ) else $error("ramp crossing did not end pulse");

    max_duty_a: assert property (
        GATE_DRIVE_OUT |-> st_q.cyc <= MAX_ON_LAST
    ) else $error("pulse beyond maximum duty");

    min_on_a: assert property (
        ($fell(GATE_DRIVE_OUT) && st_q.pwr == PWR_RUN) |-> $past(st_q.cyc) >= MIN_ON_LAST
    ) else $error("pulse shorter than minimum on-time");

    blanking_a: assert property (
        ($fell(GATE_DRIVE_OUT) && st_q.pwr == PWR_RUN && !$past(cmp.ramp_at_error))
            |-> $past(st_q.cyc) >= BLANK_END
    ) else $error("current sense acted inside blanking window");

    cs_limit_a: assert property (
        (st_q.pwr == PWR_RUN && GATE_DRIVE_OUT && sense_open && cmp.cs_above_limit
            && st_q.cyc != PERIOD_LAST) |=> !GATE_DRIVE_OUT
    ) else $error("current limit did not end pulse");

    foldback_skip_a: assert property (
        (st_q.pwr == PWR_RUN && GATE_DRIVE_OUT && sense_open && cmp.cs_above_short
            && st_q.cyc != PERIOD_LAST && cmp.vdd_above_off && !cmp.vdd_below_reset
            && st_q.line_present)
            |=> (st_q.skip == FOLD_SKIP && !GATE_DRIVE_OUT)
    ) else $error("short level did not arm three skipped cycles");

    skip_quiet_a: assert property (
        st_q.skip != '0 |-> !GATE_DRIVE_OUT
    ) else $error("pulse during foldback");

    timer_expiry_a: assert property (
        (st_q.pwr == PWR_RUN && !st_q.line_present && st_q.deb == DEB_LAST
            && cmp.vdd_above_off && !cmp.vdd_below_reset)
            |=> (st_q.pwr == PWR_HALT && st_q.swap_pending && !GATE_DRIVE_OUT)
    ) else $error("debounce expiry did not halt and arm swap");

    timer_cancel_a: assert property (
        (st_q.pwr == PWR_RUN && st_q.line_present && !cmp.vdd_below_reset)
            |=> (st_q.deb == '0 && $stable(st_q.sel))
    ) else $error("line return did not cancel timer");

    swap_powerup_a: assert property (
        (st_q.pwr == PWR_OFF && st_q.swap_pending && cmp.vdd_above_on && cmp.vdd_above_off
            && !cmp.vdd_below_reset) |=> (st_q.sel != $past(st_q.sel))
    ) else $error("pending swap not applied at power-up");

endmodule

// >>> tb/lsp_load_model.sv
// Purpose: model of the power switch, its current sense and the ramp crossing
// Assumes: ramp grows with the time the gate has been high; current flags follow cs_mode while the gate drives one selected string
// Notes: flags change just after a clock edge, like real comparators would
`timescale 1ns/1ps
module lsp_load_model
    import lsp_pkg::*;
(
    // clock
    input wire logic clk,
    // switch and string drive
    input wire logic gate,
    input wire logic sel_one,
    input wire logic sel_two,
    // commanded behaviour
    input wire logic [CYC_W-1:0] err_at,
    input wire logic [1:0] cs_mode,
    // comparator flags
    output logic ramp_at_error,
    output logic cs_above_limit,
    output logic cs_above_short
);
    logic [CYC_W-1:0] on_q = '0;
    logic flow;

    always_ff @(posedge clk) begin
        on_q <= gate ? on_q + 1'b1 : '0;
    end

    // current only flows while the switch conducts into a selected string
    assign flow = gate && (sel_one ^ sel_two);
    assign ramp_at_error = gate && (on_q >= err_at);
    // mode bits: 0 limit, 1 short; both high from the turn-on spike onward
    assign cs_above_limit = flow && cs_mode[0];
    assign cs_above_short = flow && cs_mode[1];
endmodule

// >>> tb/lsp_ctrl_tb_top.sv
// Purpose: self-checking bench of the pwm and string select controller
// Assumes: line timer shortened to 200 cycles
// Notes: inputs change on the falling edge, outputs sampled there too
`timescale 1ns/1ps
module lsp_ctrl_tb_top;
    import lsp_pkg::*;

    typedef struct {int err; logic [1:0] mode; int wlo; int whi; int per;} lsp_row_t;

    logic clk = 1'b0;
    logic rst_b, vdd_on, vdd_off, vdd_rst, line_on, line_off, ramp, cs_lim, cs_sc;
    logic gate, sel1, sel2;
    logic clk_en;
    logic [CYC_W-1:0] err_at;
    logic [1:0] cs_mode;
    int n_fail = 0;
    int num_checks = 0;
    int cyc_cnt = 0;
    int w, p;
    lsp_row_t rows [6] = '{
        '{1, 2'h0, 32, 33, 1893},
        '{400, 2'h0, 400, 407, 1893},
        '{2047, 2'h0, 1495, 1495, 1893},
        '{2047, 2'h1, 94, 96, 1893},
        '{2047, 2'h2, 94, 96, 7572},
        '{2047, 2'h3, 94, 96, 7572}
    };

    always #4 clk = ~clk;

    lsp_ctrl #(.DEBOUNCE_CYCLES(200)) dut_u (
        .CLOCK(clk), .RST_B(rst_b), .CLK_EN(clk_en),
        .VDD_ABOVE_ON(vdd_on), .VDD_ABOVE_OFF(vdd_off), .VDD_BELOW_RESET(vdd_rst),
        .LINE_ABOVE_ON(line_on), .LINE_BELOW_OFF(line_off),
        .RAMP_AT_ERROR(ramp), .CS_ABOVE_LIMIT(cs_lim), .CS_ABOVE_SHORT(cs_sc),
        .GATE_DRIVE_OUT(gate), .STRING_ONE_SELECT(sel1), .STRING_TWO_SELECT(sel2)
    );

    lsp_load_model load_u (
        .clk(clk), .gate(gate), .sel_one(sel1), .sel_two(sel2),
        .err_at(err_at), .cs_mode(cs_mode),
        .ramp_at_error(ramp), .cs_above_limit(cs_lim), .cs_above_short(cs_sc)
    );

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(string name, logic [31:0] lo, logic [31:0] hi, logic [31:0] got);
        num_checks++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            n_fail++;
            $display("[ERR] %s expected %0d..%0d seen %0d", name, lo, hi, got);
        end
    endtask

    task automatic wt(int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic pwr(logic on);
        vdd_on = on;
        vdd_off = on;
    endtask

    // a line loss held long enough to count, then parked inside the hysteresis band
    task automatic drop_line();
        line_on = 1'b0;
        line_off = 1'b1;
        wt(10);
        line_off = 1'b0;
    endtask

    task automatic wrise();
        while (gate === 1'b1) @(negedge clk);
        while (gate !== 1'b1) @(negedge clk);
    endtask

    task automatic pulse(output int wd, output int pd);
        wd = 0;
        while (gate !== 1'b1) @(negedge clk);
        while (gate === 1'b1) begin
            wd++;
            @(negedge clk);
        end
        pd = wd;
        while (gate !== 1'b1) begin
            pd++;
            @(negedge clk);
        end
    endtask

    // line loss outlasting the timer, then an off-on cycle of the supply
    task automatic swap(logic [31:0] exp_sel);
        wrise();
        wt(5);
        drop_line();
        wt(140);
        chk("gate before expiry", 1, 1, gate);
        wt(70);
        chk("gate after expiry", 0, 0, gate);
        chk("sel at expiry", 3 - exp_sel, 3 - exp_sel, {sel2, sel1});
        line_on = 1'b1;
        pwr(1'b0);
        wt(20);
        chk("sel powered down", 3 - exp_sel, 3 - exp_sel, {sel2, sel1});
        pwr(1'b1);
        wt(10);
        chk("sel after swap", exp_sel, exp_sel, {sel2, sel1});
        chk("gate after swap", 1, 1, gate);
    endtask

    always @(posedge clk) begin
        cyc_cnt++;
        if (cyc_cnt == 90000) begin
            n_fail++;
            conclude();
        end
    end

    initial begin
        rst_b = 1'b0;
        clk_en = 1'b1;
        pwr(1'b0);
        vdd_rst = 1'b0;
        line_on = 1'b1;
        line_off = 1'b0;
        err_at = '1;
        cs_mode = 2'h0;
        wt(16);
        chk("sel in reset", 1, 1, {sel2, sel1});
        chk("gate in reset", 0, 0, gate);
        rst_b = 1'b1;
        wt(300);
        chk("gate before supply", 0, 0, gate);
        pwr(1'b1);
        foreach (rows[i]) begin
            err_at = CYC_W'(rows[i].err);
            cs_mode = rows[i].mode;
            pulse(w, p);
            pulse(w, p);
            chk("pulse width", rows[i].wlo, rows[i].whi, w);
            chk("pulse period", rows[i].per, rows[i].per, p);
        end
        err_at = '1;
        cs_mode = 2'h0;
        // short line loss must not swap or stop switching
        wrise();
        drop_line();
        wt(90);
        line_on = 1'b1;
        wt(300);
        chk("gate after short loss", 1, 1, gate);
        chk("sel after short loss", 1, 1, {sel2, sel1});
        // clock enable low freezes every flop, synchronisers included
        clk_en = 1'b0;
        pwr(1'b0);
        wt(20);
        chk("gate frozen", 1, 1, gate);
        chk("sel frozen", 1, 1, {sel2, sel1});
        pwr(1'b1);
        clk_en = 1'b1;
        swap(2);
        swap(1);
        // supply drops before the timer runs out: no swap
        wrise();
        drop_line();
        wt(50);
        pwr(1'b0);
        wt(10);
        chk("gate below off", 0, 0, gate);
        line_on = 1'b1;
        wt(300);
        chk("sel held below off", 1, 1, {sel2, sel1});
        pwr(1'b1);
        wt(10);
        chk("sel no swap", 1, 1, {sel2, sel1});
        // deep supply loss resets the selection
        swap(2);
        pwr(1'b0);
        vdd_rst = 1'b1;
        wt(10);
        chk("sel deep loss", 1, 1, {sel2, sel1});
        vdd_rst = 1'b0;
        wt(5);
        pwr(1'b1);
        wt(10);
        chk("sel repower", 1, 1, {sel2, sel1});
        chk("gate repower", 1, 1, gate);
        // asynchronous reset mid-run returns to string one
        swap(2);
        rst_b = 1'b0;
        wt(2);
        chk("sel mid reset", 1, 1, {sel2, sel1});
        chk("gate mid reset", 0, 0, gate);
        rst_b = 1'b1;
        wt(10);
        chk("sel after reset", 1, 1, {sel2, sel1});
        chk("gate after reset", 1, 1, gate);
        conclude();
    end
endmodule
